// *** cpu_model.sv ***
// CPU core model issuing standby instructions and wake requests
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input  wire logic clk,
  input  wire logic on_sub,
  output logic      halt_exec,
  output logic      stop_exec,
  output logic      irq_request
);
  localparam int START_BIT  = 7;
  localparam int ENABLE_BIT = 0;
  logic [7:0] converter_mode_register;
  initial begin
    halt_exec = 1'b0;
    stop_exec = 1'b0;
    irq_request = 1'b0;
    converter_mode_register = 8'h81;
  end
  // A stop instruction clears the converter start and enable bits on the same edge that stop_exec is raised
  task automatic instr(input bit stop, input bit bad);
    @(posedge clk);
    if (stop) begin
      converter_mode_register[START_BIT]  <= 1'b0;
      converter_mode_register[ENABLE_BIT] <= 1'b0;
    end
    if (stop && (!on_sub || bad)) stop_exec <= 1'b1;
    else if (!stop) halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    stop_exec <= 1'b0;
  endtask
  task automatic wake(input int dly);
    repeat (dly) @(posedge clk);
    irq_request <= 1'b1;
    @(posedge clk);
    irq_request <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** standby_consts.svh ***
// Register map, reset values and field positions of the standby controller
`ifndef STANDBY_CONSTS_SVH
`define STANDBY_CONSTS_SVH

`define OFF_STAB_STATUS   12'h000
`define OFF_STAB_SELECT   12'h004
`define OFF_STANDBY_CTRL  12'h008
`define OFF_STANDBY_STATE 12'h00C

`define SEL_W             3
`define SEL_RESET         3'h7
`define CTRL_LS_STOP_BIT  0
`define STAB_STEPS        8
`define STAB_BASE_DEF     8

`endif

// *** standby_mode_controller.sv ***
// Halt / stop standby controller with stabilization wait and APB registers
//
// What this block does
// - Halt instruction stops the CPU clock
// - Running oscillators keep running during halt, low-speed one unless option set
// - Interrupt leaves halt at once, no wait
// - Stop instruction on main clock stops both high-speed oscillators
// - Interrupt releases stop mode
// - Crystal selected: wait stabilization after stop
// - Registers, flags and memory held in standby
// - Port latches and buffers held in standby
// - Halt allowed on main or subsystem clock
// - Option selects low-speed oscillator in standby
// - Counter status and time select registers
`include "standby_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module standby_mode_controller #(
  parameter int STAB_BASE = `STAB_BASE_DEF
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  halt_exec,
  input  wire logic                  stop_exec,
  input  wire logic                  irq_request,
  input  wire logic                  irq_enabled,
  input  wire logic                  cpu_on_subclock,
  input  wire logic                  external_crystal_clock,
  input  wire logic                  ls_stop_option,
  input  wire standby_pkg::osc_en_s  osc_run_req,
  output standby_pkg::osc_en_s       osc_en,
  output logic                       cpu_clk_en,
  output logic                       state_hold,
  output logic                       port_hold,
  output logic                       resume,
  output logic                       resume_to_service
);
  import standby_pkg::*;

  localparam int CW = STAB_BASE + `STAB_STEPS;

  mode_e                   mode_q;
  mode_e                   mode_d;
  logic [`SEL_W-1:0]       sel_q;
  logic                    ls_stop_q;
  logic                    opt_loaded_q;
  logic [CW-1:0]           cnt_q;
  logic [`STAB_STEPS-1:0]  elapsed;
  logic [31:0]             prdata_q;
  logic                    resume_q;
  logic                    to_service_q;
  osc_en_s                 osc_q;
  logic [CW-1:0]           wait_len_q;

  // Bus decode
  wire setup_rd  = psel & ~penable & ~pwrite;
  wire access_wr = psel & penable & pwrite;
  wire hit_stat  = paddr == `OFF_STAB_STATUS;
  wire hit_sel   = paddr == `OFF_STAB_SELECT;
  wire hit_ctrl  = paddr == `OFF_STANDBY_CTRL;
  wire hit_state = paddr == `OFF_STANDBY_STATE;
  wire mapped    = hit_stat | hit_sel | hit_ctrl | hit_state;

  wire [31:0] rd_mux = hit_stat  ? {{(32-`STAB_STEPS){1'b0}}, elapsed} :
                       hit_sel   ? {{(32-`SEL_W){1'b0}}, sel_q} :
                       hit_ctrl  ? {31'h0, ls_stop_q} :
                       hit_state ? {28'h0, mode_q} : 32'h0;

  // Mode decode
  wire in_run     = mode_q == ST_RUN;
  wire in_halt    = mode_q == ST_HALT;
  wire in_stop    = mode_q == ST_STOP;
  wire in_wait    = mode_q == ST_WAIT;
  wire standby    = in_halt | in_stop | in_wait;
  wire go_halt    = in_run & halt_exec;
  wire go_stop    = in_run & stop_exec & ~halt_exec & ~cpu_on_subclock;
  wire wake_halt  = in_halt & irq_request;
  wire wake_stop  = in_stop & irq_request;
  wire [CW-1:0] target = CW'(1) << (STAB_BASE + int'(sel_q));
  wire wait_done  = in_wait & (cnt_q >= target - CW'(1));
  wire to_run     = wake_halt | (wake_stop & ~external_crystal_clock) | wait_done;
  wire hs_off     = in_stop | go_stop;
  wire ls_off     = (standby | go_halt | go_stop) & ls_stop_q;

  genvar gi;
  generate
    for (gi = 0; gi < `STAB_STEPS; gi++) begin : g_elapsed
      assign elapsed[gi] = cnt_q >= (CW'(1) << (STAB_BASE + gi));
    end
  endgenerate

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      ST_RUN: begin
        if (go_halt) begin
          mode_d = ST_HALT;
        end else if (go_stop) begin
          mode_d = ST_STOP;
        end
      end
      ST_HALT: begin
        if (wake_halt) begin
          mode_d = ST_RUN;
        end
      end
      ST_STOP: begin
        if (wake_stop) begin
          mode_d = external_crystal_clock ? ST_WAIT : ST_RUN;
        end
      end
      ST_WAIT: begin
        if (wait_done) begin
          mode_d = ST_RUN;
        end
      end
      default: mode_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= ST_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Stabilization counter restarts on stop entry and saturates
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (go_stop) begin
      cnt_q <= '0;
    end else if (in_wait && cnt_q != '1) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // Option strap is caught in the first cycle after reset release
  always_ff @(posedge clk) begin
    if (reset) begin
      ls_stop_q    <= 1'b0;
      opt_loaded_q <= 1'b0;
    end else if (!opt_loaded_q) begin
      ls_stop_q    <= ls_stop_option;
      opt_loaded_q <= 1'b1;
    end else if (access_wr && hit_ctrl) begin
      ls_stop_q    <= pwdata[`CTRL_LS_STOP_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sel_q <= `SEL_RESET;
    end else if (access_wr && hit_sel) begin
      sel_q <= pwdata[`SEL_W-1:0];
    end
  end

  // Oscillator enables follow the requests except where standby forces them off
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_q <= '0;
    end else begin
      osc_q.hs_sys  <= osc_run_req.hs_sys & ~hs_off;
      osc_q.ih_osc  <= osc_run_req.ih_osc & ~hs_off;
      osc_q.sub_osc <= osc_run_req.sub_osc;
      osc_q.ls_osc  <= osc_run_req.ls_osc & ~ls_off;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      resume_q     <= 1'b0;
      to_service_q <= 1'b0;
    end else begin
      resume_q     <= to_run;
      to_service_q <= to_run & irq_enabled;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_q <= 32'h0;
    end else if (setup_rd) begin
      prdata_q <= rd_mux;
    end
  end

  // Independent count of WAIT cycles; only the wait-length check reads it
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_len_q <= '0;
    end else if (wake_stop) begin
      wait_len_q <= '0;
    end else if (in_wait) begin
      wait_len_q <= wait_len_q + CW'(1);
    end
  end

  assign prdata            = prdata_q;
  assign pready            = 1'b1;
  assign pslverr           = psel & penable & ~mapped;
  assign osc_en            = osc_q;
  assign cpu_clk_en        = in_run;
  assign state_hold        = standby;
  assign port_hold         = standby;
  assign resume            = resume_q;
  assign resume_to_service = to_service_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  halt_entry_a: assert property (go_halt |=> in_halt && !cpu_clk_en)
    else $error("halt entry did not stop cpu clock");
  halt_osc_a: assert property (in_halt && osc_run_req.hs_sys |=> osc_en.hs_sys)
    else $error("oscillator dropped in halt");
  halt_wake_a: assert property (in_halt && irq_request |=> in_run ##0 resume)
    else $error("halt not left immediately");
  stop_osc_a: assert property (in_stop |-> !osc_en.hs_sys && !osc_en.ih_osc)
    else $error("high-speed oscillator running in stop");
  stop_wake_a: assert property (in_stop && irq_request |=> in_run || in_wait)
    else $error("stop not released by interrupt");
  stop_wait_a: assert property (in_stop && irq_request && external_crystal_clock |=>
    in_wait && !cpu_clk_en) else $error("no stabilization wait");
  hold_flag_a: assert property (!in_run |-> state_hold && port_hold)
    else $error("hold released in standby");
  sub_stop_a: assert property (in_run && stop_exec && cpu_on_subclock && !halt_exec
    |=> in_run) else $error("stop entered on subsystem clock");
  ls_opt_a: assert property (in_halt && ls_stop_q |=> !osc_en.ls_osc)
    else $error("low-speed oscillator kept despite option");
  sel_write_a: assert property (access_wr && hit_sel |=> sel_q == $past(pwdata[`SEL_W-1:0]))
    else $error("time select not written");
  resume_svc_a: assert property (to_run && irq_enabled |=> resume_to_service)
    else $error("service resume flag missing");

  // Entry into and exit from the standby modes
  stop_entry_a: assert property (go_stop |=> in_stop && !cpu_clk_en &&
    !osc_en.hs_sys && !osc_en.ih_osc) else $error("stop entry left oscillators running");
  halt_sub_a: assert property (in_run && halt_exec && cpu_on_subclock |=> in_halt)
    else $error("halt refused on subsystem clock");
  halt_clk_a: assert property (wake_halt |=> cpu_clk_en && !state_hold && !port_hold)
    else $error("cpu clock not back after halt wake");
  halt_hold_a: assert property (go_halt |=> state_hold && port_hold)
    else $error("hold not raised on halt entry");
  standby_stay_a: assert property ((in_halt || in_stop) && !irq_request
    |=> $stable(mode_q)) else $error("standby left without interrupt");
  direct_wake_a: assert property (wake_stop && !external_crystal_clock |=>
    in_run && resume) else $error("stop without crystal not left at once");
  wait_entry_a: assert property (wake_stop && external_crystal_clock |=>
    in_wait && !resume) else $error("resumed before stabilization wait");
  wait_stay_a: assert property (in_wait && !wait_done |=> in_wait && !cpu_clk_en)
    else $error("stabilization wait cut short");
  wait_len_a: assert property (wait_done |=> in_run && wait_len_q >= $past(target))
    else $error("stabilization wait shorter than selected");
  status_clear_a: assert property (go_stop |=> elapsed == '0)
    else $error("elapsed status not cleared on stop entry");

  // Oscillator enables
  halt_ih_a: assert property (in_halt && osc_run_req.ih_osc |=> osc_en.ih_osc)
    else $error("internal oscillator dropped in halt");
  sub_osc_a: assert property (osc_run_req.sub_osc |=> osc_en.sub_osc)
    else $error("subsystem oscillator dropped");
  wait_osc_a: assert property (in_wait && osc_run_req.hs_sys |=> osc_en.hs_sys)
    else $error("crystal not restarted for stabilization");
  ls_run_a: assert property (in_run && !go_halt && !go_stop && osc_run_req.ls_osc |=>
    osc_en.ls_osc) else $error("low-speed oscillator stopped while running");
  halt_ls_keep_a: assert property (in_halt && !ls_stop_q && osc_run_req.ls_osc |=>
    osc_en.ls_osc) else $error("low-speed oscillator stopped against option");
  stop_ls_a: assert property (in_stop && ls_stop_q |=> !osc_en.ls_osc)
    else $error("low-speed oscillator kept in stop despite option");

  // Retention and resume
  sel_hold_a: assert property (standby && !(access_wr && hit_sel) |=> $stable(sel_q))
    else $error("time select changed in standby");
  ctrl_hold_a: assert property (standby && !(access_wr && hit_ctrl)
    |=> $stable(ls_stop_q)) else $error("option bit changed in standby");
  resume_next_a: assert property (to_run && !irq_enabled |=>
    resume && !resume_to_service) else $error("next-instruction resume wrong");
  resume_pulse_a: assert property (resume |=> !resume)
    else $error("resume longer than one cycle");

  halt_cycle_c: cover property (go_halt ##[1:20] wake_halt);
  stop_direct_c: cover property (go_stop ##[1:20] (wake_stop && !external_crystal_clock));
  stop_wait_c: cover property (wake_stop && external_crystal_clock ##[1:1000] wait_done);
  halt_sub_c: cover property (go_halt && cpu_on_subclock);
  wait_service_c: cover property (wait_done && irq_enabled);

endmodule

`default_nettype wire

// *** standby_pkg.sv ***
// Types shared by the standby controller
package standby_pkg;

  typedef enum logic [3:0] {
    ST_RUN  = 4'b0001,
    ST_HALT = 4'b0010,
    ST_STOP = 4'b0100,
    ST_WAIT = 4'b1000
  } mode_e;

  typedef struct packed {
    logic hs_sys;
    logic ih_osc;
    logic sub_osc;
    logic ls_osc;
  } osc_en_s;

endpackage

// *** standby_tb.sv ***
// Self-checking bench for the standby mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import standby_pkg::*;
  localparam int B = 2;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, halt_exec, stop_exec, irq_request, opt;
  logic        irq_enabled = 1'b0, on_sub = 1'b0, xtal = 1'b0, ls_opt = 1'b0;
  osc_en_s     req = '0, osc_en, e;
  logic        cpu_clk_en, state_hold, port_hold, resume, resume_to_service;
  int          n_mismatch = 0, n_checks = 0, d, d0, sel;
  always #5 clk = ~clk;
  cpu_model cpu_u (.clk, .on_sub, .halt_exec, .stop_exec, .irq_request);
  standby_mode_controller #(.STAB_BASE(B)) dut_u (
    .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .halt_exec, .stop_exec, .irq_request, .irq_enabled, .cpu_on_subclock(on_sub),
    .external_crystal_clock(xtal), .ls_stop_option(ls_opt), .osc_run_req(req), .osc_en,
    .cpu_clk_en, .state_hold, .port_hold, .resume, .resume_to_service);
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: value %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] wd);
    int i;
    i = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk) penable <= 1'b1;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_mismatch++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Enter one standby mode, check the held outputs, then wake and count cycles
  task automatic standby(input bit stop, input logic [31:0] st);
    cpu_u.instr(stop, 1'b0);
    repeat (3) @(posedge clk);
    e = req;
    if (stop) e.hs_sys = 1'b0;
    if (stop) e.ih_osc = 1'b0;
    if (opt) e.ls_osc = 1'b0;
    chk(32'(cpu_clk_en), 32'h0);
    chk(32'({state_hold, port_hold}), 32'h3);
    chk(32'(osc_en), 32'(e));
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, st);
    cpu_u.wake(3);
    d = 0;
    while (resume !== 1'b1 && d < 2000) begin
      @(posedge clk);
      d++;
    end
    if (d >= 2000) begin
      n_mismatch++;
      close_out();
    end
    chk(32'(resume_to_service), 32'(irq_enabled));
    repeat (2) @(posedge clk);
    chk(32'(cpu_clk_en), 32'h1);
  endtask
  initial begin
    void'($urandom(32'hC1199727));
    ls_opt = 1'($urandom);
    req = 4'($urandom);
    opt = ls_opt;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h7);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'(opt));
    apb(1'b1, 12'h00C, 32'h8);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test registers done");
    sel = $urandom % 8;
    apb(1'b1, 12'h004, 32'(sel));
    for (int k = 0; k < 4; k++) begin
      on_sub <= k[0];
      irq_enabled <= k[1];
      xtal <= k[1];
      opt = k[1];
      apb(1'b1, 12'h008, 32'(k[1]));
      standby(1'b0, 32'h2);
      chk(32'(d <= 3), 32'h1);
    end
    $display("test halt done");
    on_sub <= 1'b0;
    xtal <= 1'b0;
    standby(1'b1, 32'h4);
    d0 = d;
    xtal <= 1'b1;
    standby(1'b1, 32'h4);
    chk(32'(d - d0), 32'(1 << (B + sel)));
    chk(32'(cpu_u.converter_mode_register), 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'((1 << (sel + 1)) - 1));
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'(sel));
    on_sub <= 1'b1;
    cpu_u.instr(1'b1, 1'b1);
    repeat (3) @(posedge clk);
    chk(32'(cpu_clk_en), 32'h1);
    $display("test stop done");
    cpu_u.instr(1'b0, 1'b0);
    repeat (2) @(posedge clk);
    chk(32'(cpu_clk_en), 32'h0);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(32'({cpu_clk_en, state_hold, resume, osc_en}), 32'h40);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h7);
    $display("test reset done");
    close_out();
  end
endmodule
`default_nettype wire
